// *** rtl/isabr_defs.svh ***
// constants for the isa bus signalling block
// assumes a 25 MHz core clock that is also the host bus clock
`ifndef ISABR_DEFS_SVH
`define ISABR_DEFS_SVH
`define ISABR_CORE_MHZ     25
`define ISABR_DIV_FAST     3
`define ISABR_DIV_SLOW     4
`define ISABR_CMD8_TICKS   3
`define ISABR_CMD16_TICKS  1
`define ISABR_DRV_SETUP    1
`define ISABR_LA_MSB       23
`define ISABR_LA_LSB       17
`define ISABR_SEL_SEC_CMD  6
`define ISABR_SEL_SEC_CTRL 5
`define ISABR_SEL_PRI_CMD  4
`define ISABR_SEL_PRI_CTRL 3
`endif

// *** rtl/isabr_pkg.sv ***
// types for the isa bus signalling block
// assumes isabr_defs.svh for numeric constants
package isabr_pkg;
  typedef enum logic [2:0] {K_IO_RD, K_IO_WR, K_DRV_RD, K_DRV_WR, K_DMA, K_REFRESH} isabr_kind_e;
  typedef enum logic [1:0] {B_PRI_CMD, B_PRI_CTRL, B_SEC_CMD, B_SEC_CTRL} isabr_blk_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_HOLD} isabr_state_e;
endpackage

// *** rtl/isabr_clkdiv.sv ***
// isa clock divider: level and rising-edge enable from the core clock
// assumes run is low until the divisor strap is settled
`timescale 1ns/1ps
`default_nettype none
`include "isabr_defs.svh"
module isabr_clkdiv (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // control
  input  wire logic run,
  input  wire logic div3,
  // divided clock
  output logic      level,
  output logic      tick
);
  logic [2:0] cnt;
  logic [2:0] last;

  assign last = div3 ? 3'(`ISABR_DIV_FAST - 1) : 3'(`ISABR_DIV_SLOW - 1);

  // count through one isa period
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt <= 3'h0;
    else if (!run || cnt == last)
      cnt <= 3'h0;
    else
      cnt <= cnt + 3'h1;
  end

  // high for the first two counts, rise enable at count zero
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      level <= 1'b0;
      tick  <= 1'b0;
    end
    else
    begin
      level <= run && cnt < 3'h2;
      tick  <= run && cnt == 3'h0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/isabr_bus.sv ***
// isa bus signalling with drive select sharing of the unlatched address pins
// assumes requests and pins are synchronous to core_clk; pin levels resolved outside
`timescale 1ns/1ps
`default_nettype none
`include "isabr_defs.svh"
module isabr_bus #(
  parameter bit EARLY_VARIANT   = 1'b1,
  parameter int CMD8_TICKS      = `ISABR_CMD8_TICKS,
  parameter int CMD16_TICKS     = `ISABR_CMD16_TICKS,
  parameter int DRV_SETUP_TICKS = `ISABR_DRV_SETUP
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // power and straps
  input  wire logic                  power_good,
  input  wire logic                  tc_in,
  // cycle requests
  input  wire logic                  req_valid,
  input  wire isabr_pkg::isabr_kind_e req_kind,
  input  wire logic [23:0]           req_addr,
  input  wire isabr_pkg::isabr_blk_e req_block,
  input  wire logic [2:0]            req_disk_addr,
  output logic                       req_ready,
  output logic                       req_done,
  output logic                       req_wide,
  // external master
  input  wire logic                  ext_master_grant,
  input  wire logic                  ext_local_access,
  input  wire logic                  ext_local_ready,
  output logic [6:0]                 ext_master_la,
  // error reporting
  input  wire logic                  iochk_n,
  input  wire logic                  nmi_enable,
  output logic                       nmi,
  // isa clock pin
  input  wire logic                  sysclk_in,
  output logic                       sysclk_out,
  output logic                       sysclk_oe,
  // isa control
  output logic                       bale,
  output logic                       aen,
  output logic                       aen_oe,
  input  wire logic                  iocs16_n,
  input  wire logic                  iochrdy_in,
  output logic                       iochrdy_out,
  output logic                       iochrdy_oe,
  output logic                       ior_out_n,
  output logic                       iow_out_n,
  output logic                       cmd_oe,
  // drive strobes
  output logic                       disk_read_n,
  output logic                       disk_write_n,
  // shared unlatched address pins
  input  wire logic [6:0]            la_in,
  output logic [6:0]                 la_out,
  output logic                       la_oe,
  // address transceiver
  output logic                       addr_transceiver_enable_n,
  output logic                       addr_transceiver_direction
);
  isabr_pkg::isabr_state_e state;
  isabr_pkg::isabr_kind_e  kind;
  isabr_pkg::isabr_blk_e   blk;
  logic [6:0] addr_hi;
  logic [2:0] dsk;
  logic [2:0] cnt;
  logic       pg_q;
  logic       strapped;
  logic       div3;
  logic       ext_dma_mode;
  logic       ext_own;
  logic       div_level;
  logic       tick;
  logic       is_drv;
  logic       is_dmaref;
  logic       rdy_ok;
  logic [6:0] next_la;

  if (CMD8_TICKS < 1 || CMD8_TICKS > 7 || CMD16_TICKS < 1 || CMD16_TICKS > 7 ||
      DRV_SETUP_TICKS < 1 || DRV_SETUP_TICKS > 7)
  begin : g_bad_ticks
    $error("isabr_bus: tick counts must lie in 1..7");
  end

  isabr_clkdiv u_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .run      (strapped),
    .div3     (div3),
    .level    (div_level),
    .tick     (tick)
  );

  // divisor and dma-mode straps taken at power good rise
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pg_q         <= 1'b0;
      strapped     <= 1'b0;
      div3         <= 1'b0;
      ext_dma_mode <= 1'b0;
    end
    else
    begin
      pg_q <= power_good;
      if (!power_good)
        strapped <= 1'b0;
      else if (!pg_q)
      begin
        strapped     <= 1'b1;
        div3         <= sysclk_in;
        ext_dma_mode <= EARLY_VARIANT && !tc_in;
      end
    end
  end

  // isa clock pin
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sysclk_out <= 1'b0;
      sysclk_oe  <= 1'b0;
    end
    else
    begin
      sysclk_out <= strapped && div_level;
      sysclk_oe  <= strapped && power_good;
    end
  end

  assign is_drv    = kind == isabr_pkg::K_DRV_RD || kind == isabr_pkg::K_DRV_WR;
  assign is_dmaref = kind == isabr_pkg::K_DMA || kind == isabr_pkg::K_REFRESH;
  assign rdy_ok    = is_drv || ext_own || iochrdy_in;

  // bus ownership changes only between cycles
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      ext_own <= 1'b0;
    else if (state == isabr_pkg::ST_IDLE && !(req_valid && req_ready))
      ext_own <= ext_master_grant;
  end

  // cycle sequencer leaves idle on the request handshake, then steps on isa clock rise
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state    <= isabr_pkg::ST_IDLE;
      kind     <= isabr_pkg::K_IO_RD;
      blk      <= isabr_pkg::B_PRI_CMD;
      addr_hi  <= 7'h00;
      dsk      <= 3'h0;
      cnt      <= 3'h0;
      req_wide <= 1'b0;
    end
    else
    begin
      unique case (state)
        isabr_pkg::ST_IDLE:
        begin
          if (req_valid && req_ready)
          begin
            state   <= isabr_pkg::ST_ADDR;
            kind    <= req_kind;
            blk     <= req_block;
            addr_hi <= req_addr[`ISABR_LA_MSB:`ISABR_LA_LSB];
            dsk     <= req_disk_addr;
            cnt     <= 3'(DRV_SETUP_TICKS - 1);
          end
        end
        isabr_pkg::ST_ADDR:
        begin
          if (tick && (cnt == 3'h0 || !is_drv))
          begin
            state    <= isabr_pkg::ST_CMD;
            req_wide <= !iocs16_n && !is_drv;
            cnt      <= !iocs16_n ? 3'(CMD16_TICKS - 1) : 3'(CMD8_TICKS - 1);
          end
          else if (tick)
            cnt <= cnt - 3'h1;
        end
        isabr_pkg::ST_CMD:
        begin
          if (tick && cnt != 3'h0)
            cnt <= cnt - 3'h1;
          else if (tick && rdy_ok)
            state <= isabr_pkg::ST_HOLD;
        end
        isabr_pkg::ST_HOLD:
        begin
          if (tick)
            state <= isabr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // request handshake
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_ready <= 1'b0;
      req_done  <= 1'b0;
    end
    else
    begin
      req_ready <= state == isabr_pkg::ST_IDLE && !(req_valid && req_ready) &&
                   strapped && !ext_master_grant && !ext_own;
      req_done  <= state == isabr_pkg::ST_HOLD && tick;
    end
  end

  // shared pin contents
  always_comb
  begin
    next_la = addr_hi;
    if (state != isabr_pkg::ST_IDLE && is_drv)
    begin
      next_la = 7'h00;
      next_la[`ISABR_SEL_SEC_CMD]  = blk == isabr_pkg::B_SEC_CMD;
      next_la[`ISABR_SEL_SEC_CTRL] = blk == isabr_pkg::B_SEC_CTRL;
      next_la[`ISABR_SEL_PRI_CMD]  = blk == isabr_pkg::B_PRI_CMD;
      next_la[`ISABR_SEL_PRI_CTRL] = blk == isabr_pkg::B_PRI_CTRL;
      next_la[2:0]                 = dsk;
    end
  end

  // unlatched address pins both ways
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      la_out        <= 7'h00;
      la_oe         <= 1'b0;
      ext_master_la <= 7'h00;
    end
    else
    begin
      la_out <= next_la;
      la_oe  <= !ext_own;
      if (ext_own)
        ext_master_la <= la_in;
    end
  end

  // address strobe, address enable and command strobes
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bale         <= 1'b0;
      aen          <= 1'b0;
      aen_oe       <= 1'b0;
      ior_out_n    <= 1'b1;
      iow_out_n    <= 1'b1;
      cmd_oe       <= 1'b0;
      disk_read_n  <= 1'b1;
      disk_write_n <= 1'b1;
    end
    else
    begin
      bale         <= state == isabr_pkg::ST_ADDR && !is_drv;
      aen          <= state != isabr_pkg::ST_IDLE && is_dmaref;
      aen_oe       <= !ext_dma_mode;
      ior_out_n    <= !(state == isabr_pkg::ST_CMD && kind == isabr_pkg::K_IO_RD);
      iow_out_n    <= !(state == isabr_pkg::ST_CMD && kind == isabr_pkg::K_IO_WR);
      cmd_oe       <= !ext_own;
      disk_read_n  <= !(state == isabr_pkg::ST_CMD && kind == isabr_pkg::K_DRV_RD);
      disk_write_n <= !(state == isabr_pkg::ST_CMD && kind == isabr_pkg::K_DRV_WR);
    end
  end

  // channel ready for external master local hits, transceiver pair and nmi
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      iochrdy_out                <= 1'b1;
      iochrdy_oe                 <= 1'b0;
      addr_transceiver_enable_n  <= 1'b0;
      addr_transceiver_direction <= 1'b1;
      nmi                        <= 1'b0;
    end
    else
    begin
      iochrdy_oe                 <= ext_own && ext_local_access;
      iochrdy_out                <= ext_local_ready;
      addr_transceiver_enable_n  <= !ext_own && state != isabr_pkg::ST_IDLE && is_drv;
      addr_transceiver_direction <= !ext_own;
      nmi                        <= nmi_enable && !iochk_n;
    end
  end

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  drv_sel_onehot_a: assert property ((!disk_read_n || !disk_write_n) |-> $onehot(la_out[6:3]))
    else $error("drive strobe without one block select");
  drv_addr_hold_a: assert property ((!disk_read_n && !$past(disk_read_n)) |-> $stable(la_out))
    else $error("drive address moved under strobe");
  drv_addr_setup_a: assert property ($fell(disk_read_n) |-> $stable(la_out))
    else $error("disk address not set up before strobe");
  bale_addr_valid_a: assert property (bale |-> la_oe && addr_transceiver_direction)
    else $error("bale without driven address");
  aen_dma_cycle_a: assert property ((state == isabr_pkg::ST_CMD && kind == isabr_pkg::K_DMA) |=> aen)
    else $error("aen low in dma cycle");
  aen_refresh_a: assert property ((state == isabr_pkg::ST_CMD && kind == isabr_pkg::K_REFRESH) |=> aen)
    else $error("aen low in refresh");
  aen_float_a: assert property (ext_dma_mode |=> !aen_oe)
    else $error("aen driven in external dma mode");
  sysclk_float_a: assert property (!power_good |=> !sysclk_oe)
    else $error("isa clock driven without power good");
  sysclk_div3_a: assert property (($rose(sysclk_out) && div3 && power_good) |-> ##3 ($rose(sysclk_out) || !strapped))
    else $error("isa clock period not three");
  wait_extend_a: assert property ((state == isabr_pkg::ST_CMD && tick && cnt == 3'h0 && !rdy_ok) |=> state == isabr_pkg::ST_CMD)
    else $error("cycle ended while not ready");
  rdy_drive_a: assert property (iochrdy_oe |-> $past(ext_own))
    else $error("ready driven without external master");
  io_cmd_excl_a: assert property (!ior_out_n |-> cmd_oe && iow_out_n)
    else $error("io read and write together");
  trx_master_a: assert property ((ext_own && $past(ext_own)) |=> !addr_transceiver_enable_n && !addr_transceiver_direction)
    else $error("transceiver not turned for master");
  nmi_report_a: assert property ((!iochk_n && nmi_enable) |=> nmi)
    else $error("channel check not reported");

  io_read_c: cover property (!ior_out_n ##1 ior_out_n);
  drv_write_c: cover property ($fell(disk_write_n));
  wait_state_c: cover property (state == isabr_pkg::ST_CMD && tick && cnt == 3'h0 && !iochrdy_in);
  dma_cycle_c: cover property ($rose(aen));
endmodule
`default_nettype wire

// *** verif/isabr_isa_model.sv ***
// isa side partner: slave with wait states and wide decode, clock strap resistor
// assumes command strobes and enables come straight from the bridge block
`timescale 1ns/1ps
`default_nettype none
module isabr_isa_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // bridge pins
  input  wire logic       ior_out_n,
  input  wire logic       iow_out_n,
  input  wire logic       cmd_oe,
  input  wire logic       iochrdy_out,
  input  wire logic       iochrdy_oe,
  input  wire logic       sysclk_out,
  input  wire logic       sysclk_oe,
  // behaviour set by the bench
  input  wire logic       strap_high,
  input  wire logic       wide_slave,
  input  wire logic [3:0] wait_clks,
  // resolved lines
  output logic            iochrdy_in,
  output logic            iocs16_n,
  output logic            sysclk_in
);
  logic       cmd_low;
  logic       cmd_q;
  logic [3:0] wait_cnt;
  logic       slave_rdy;
  assign cmd_low = cmd_oe & (~ior_out_n | ~iow_out_n);
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_q    <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else
    begin
      cmd_q <= cmd_low;
      if (cmd_low && !cmd_q)
        wait_cnt <= wait_clks;
      else if (wait_cnt != 4'h0)
        wait_cnt <= wait_cnt - 4'h1;
    end
  end
  // slave holds ready low while it needs time, line rests high on its pull-up
  assign slave_rdy  = ~(cmd_low && (cmd_q ? wait_cnt != 4'h0 : wait_clks != 4'h0));
  assign iochrdy_in = iochrdy_oe ? iochrdy_out : slave_rdy;
  assign iocs16_n   = ~wide_slave;
  assign sysclk_in  = sysclk_oe ? sysclk_out : strap_high;
endmodule
`default_nettype wire

// *** verif/isa_bus_signaling_with_ide_select_mux_tb.sv ***
// bench for the isa bus signalling block
// assumes the isa partner model and the block are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "isabr_defs.svh"
module isa_bus_signaling_with_ide_select_mux_tb;
  localparam int C8  = `ISABR_CMD8_TICKS;
  localparam int C16 = `ISABR_CMD16_TICKS;
  logic core_clk = 0, rst_b = 0, power_good = 0, tc_in = 1, req_valid = 0;
  isabr_pkg::isabr_kind_e req_kind  = isabr_pkg::K_IO_RD;
  isabr_pkg::isabr_blk_e  req_block = isabr_pkg::B_PRI_CMD;
  logic [23:0] req_addr = 24'h0;
  logic [2:0]  req_disk_addr = 3'h0;
  logic ext_master_grant = 0, ext_local_access = 0, ext_local_ready = 0;
  logic iochk_n = 1, nmi_enable = 0, strap = 1, wide = 0;
  logic [3:0] waits = 4'h0;
  logic [6:0] ext_la = 7'h2A, la_in, la_out, ext_master_la, m_la_bale, m_la_str;
  logic req_ready, req_done, req_wide, nmi, sysclk_in, sysclk_out, sysclk_oe, bale, aen;
  logic aen_oe, iocs16_n, iochrdy_in, iochrdy_out, iochrdy_oe, ior_out_n, iow_out_n, cmd_oe;
  logic disk_read_n, disk_write_n, la_oe, addr_transceiver_enable_n, addr_transceiver_direction;
  logic m_bale, m_ior, m_iow, m_drd, m_dwr, m_aen, m_moved, m_setup;
  logic [1:0] m_trx;
  int m_len, errors = 0, checks = 0;
  assign la_in = la_oe ? la_out : (ext_master_grant ? ext_la : ~la_out);
  isabr_bus #(.EARLY_VARIANT(1'b1), .CMD8_TICKS(C8), .CMD16_TICKS(C16), .DRV_SETUP_TICKS(1))
  dut_u (.core_clk, .rst_b, .power_good, .tc_in, .req_valid, .req_kind, .req_addr, .req_block,
    .req_disk_addr, .req_ready, .req_done, .req_wide, .ext_master_grant, .ext_local_access,
    .ext_local_ready, .ext_master_la, .iochk_n, .nmi_enable, .nmi, .sysclk_in, .sysclk_out,
    .sysclk_oe, .bale, .aen, .aen_oe, .iocs16_n, .iochrdy_in, .iochrdy_out, .iochrdy_oe,
    .ior_out_n, .iow_out_n, .cmd_oe, .disk_read_n, .disk_write_n, .la_in, .la_out, .la_oe,
    .addr_transceiver_enable_n, .addr_transceiver_direction);
  isabr_isa_model isa_u (.core_clk, .rst_b, .ior_out_n, .iow_out_n, .cmd_oe, .iochrdy_out,
    .iochrdy_oe, .sysclk_out, .sysclk_oe, .strap_high(strap), .wide_slave(wide),
    .wait_clks(waits), .iochrdy_in, .iocs16_n, .sysclk_in);
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 300 && req_ready !== 1'b1; i++) tick(1);
  endtask
  task automatic power_up(input logic s, input logic t);
    int n;
    rst_b = 0;
    power_good = 0;
    strap = s;
    tc_in = t;
    tick(6);
    chk_bit(sysclk_oe, 1'b0);
    chk_vec({ior_out_n, iow_out_n, disk_read_n, disk_write_n, bale}, 5'h1E);
    rst_b = 1;
    tick(3);
    chk_bit(sysclk_oe, 1'b0);
    power_good = 1;
    wait_ready();
    chk_bit(aen_oe, t);
    chk_bit(sysclk_oe, 1'b1);
    n = 0;
    for (int i = 0; i < 9 && sysclk_out !== 1'b0; i++) tick(1);
    for (int i = 0; i < 9 && sysclk_out !== 1'b1; i++) tick(1);
    while (sysclk_out === 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    while (sysclk_out !== 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    chk_vec(n, s ? `ISABR_DIV_FAST : `ISABR_DIV_SLOW);
  endtask
  task automatic run(input isabr_pkg::isabr_kind_e k, input logic [23:0] a,
                     input isabr_pkg::isabr_blk_e b, input logic [2:0] d);
    logic s;
    logic [6:0] pre;
    wait_ready();
    req_kind = k;
    req_addr = a;
    req_block = b;
    req_disk_addr = d;
    req_valid = 1;
    tick(1);
    req_valid = 0;
    {m_bale, m_ior, m_iow, m_drd, m_dwr, m_aen, m_moved, m_setup, m_len} = 0;
    pre = la_out;
    for (int i = 0; i < 400 && req_done !== 1'b1; i++)
    begin
      tick(1);
      s = ~(ior_out_n & iow_out_n & disk_read_n & disk_write_n);
      if (bale === 1'b1)
        {m_bale, m_la_bale} = {1'b1, la_out};
      {m_ior, m_iow, m_drd, m_dwr} = {m_ior, m_iow, m_drd, m_dwr} |
                                     ~{ior_out_n, iow_out_n, disk_read_n, disk_write_n};
      m_aen |= aen;
      if (s === 1'b1 && m_len == 0)
        {m_la_str, m_setup, m_trx} = {la_out, pre === la_out,
                                       addr_transceiver_enable_n, addr_transceiver_direction};
      else if (s === 1'b1 && la_out !== m_la_str)
        m_moved = 1;
      if (s === 1'b1)
        m_len++;
      pre = la_out;
    end
    chk_bit(req_done, 1'b1);
  endtask
  task automatic t_drive;
    isabr_pkg::isabr_blk_e b;
    int p;
    for (int i = 0; i < 4; i++)
    begin
      b = isabr_pkg::isabr_blk_e'(i);
      p = (b == isabr_pkg::B_SEC_CMD) ? `ISABR_SEL_SEC_CMD :
          (b == isabr_pkg::B_SEC_CTRL) ? `ISABR_SEL_SEC_CTRL :
          (b == isabr_pkg::B_PRI_CMD) ? `ISABR_SEL_PRI_CMD : `ISABR_SEL_PRI_CTRL;
      run(i[0] ? isabr_pkg::K_DRV_WR : isabr_pkg::K_DRV_RD, 24'hFFFFFF, b, 3'(2 * i + 1));
      chk_vec(m_la_str, (7'h01 << p) | 7'(2 * i + 1));
      chk_vec({m_moved, m_setup, m_bale}, 3'h2);
      chk_vec({m_drd, m_dwr, m_ior, m_iow}, i[0] ? 4'h4 : 4'h8);
      chk_vec(m_trx, 2'h3);
    end
  endtask
  task automatic t_io;
    run(isabr_pkg::K_IO_RD, 24'hB40000, isabr_pkg::B_PRI_CMD, 3'h0);
    chk_bit(m_bale, 1'b1);
    chk_vec(m_la_bale, 7'h5A);
    chk_vec({m_ior, m_iow, m_aen}, 3'h4);
    chk_vec(m_len, `ISABR_DIV_FAST * C8);
    chk_bit(req_wide, 1'b0);
    chk_vec(m_trx, 2'h1);
    wide = 1;
    run(isabr_pkg::K_IO_WR, 24'h060000, isabr_pkg::B_PRI_CMD, 3'h0);
    chk_vec({m_ior, m_iow, req_wide}, 3'h3);
    chk_vec(m_len, `ISABR_DIV_FAST * C16);
    waits = 4'h7;
    run(isabr_pkg::K_IO_WR, 24'h060000, isabr_pkg::B_PRI_CMD, 3'h0);
    chk_bit(m_len >= `ISABR_DIV_FAST * (C16 + 1), 1'b1);
    {waits, wide} = 0;
  endtask
  task automatic t_dma;
    for (int i = 4; i < 6; i++)
    begin
      run(isabr_pkg::isabr_kind_e'(i), 24'h0, isabr_pkg::B_PRI_CMD, 3'h0);
      chk_vec({m_aen, m_ior, m_iow}, 3'h4);
      tick(2);
      chk_bit(aen, 1'b0);
    end
  endtask
  task automatic t_nmi;
    {nmi_enable, iochk_n} = 2'h2;
    tick(2);
    chk_bit(nmi, 1'b1);
    nmi_enable = 0;
    tick(2);
    chk_bit(nmi, 1'b0);
    {nmi_enable, iochk_n} = 2'h3;
    tick(2);
    chk_bit(nmi, 1'b0);
  endtask
  task automatic t_ext;
    {ext_master_grant, ext_local_access, ext_local_ready} = 3'h6;
    tick(3);
    chk_vec({addr_transceiver_enable_n, addr_transceiver_direction, la_oe, cmd_oe}, 4'h0);
    chk_vec({ext_master_la, req_ready}, {ext_la, 1'b0});
    chk_vec({iochrdy_oe, iochrdy_in}, 2'h2);
    ext_local_ready = 1;
    tick(2);
    chk_bit(iochrdy_in, 1'b1);
    ext_local_access = 0;
    tick(2);
    chk_bit(iochrdy_oe, 1'b0);
    ext_master_grant = 0;
    tick(3);
    chk_vec({addr_transceiver_enable_n, addr_transceiver_direction}, 2'h1);
  endtask
  initial
  begin
    #1;
    power_up(1'b1, 1'b1);
    t_drive();
    t_io();
    t_dma();
    t_nmi();
    t_ext();
    power_up(1'b0, 1'b0);
    final_report();
  end
  initial
  begin
    #2000000;
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
